// file: dv/ric_host_model.sv
/*
 * Host microcontroller model: single-cycle register strobes.
 * Assumes rdata is registered on the taking edge itself and read 1 ns later.
 */
`timescale 1ns/1ps

module ric_host_model (
   input  wire logic              clk_i,
   input  wire logic [7:0]        rdata_i,
   output ric_pkg::ric_host_req_s host_o
);
   initial host_o = '0;

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      host_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      host_o <= '0;
      #1;
   endtask : wr

   // the host releases irq with this status read or with a control write
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_i);
      host_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      host_o <= '0;
      #1;
      d = rdata_i;
   endtask : rd
endmodule : ric_host_model

// file: dv/ric_irq_monitor.sv
/*
 * Port-level assertion checker for the interrupt status block.
 * Assumes it is bound onto ric_irq_status; one clock, async low reset.
 */
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_irq_monitor (
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire ric_pkg::ric_host_req_s host_i,
   input wire ric_pkg::ric_events_s   ev_i,
   input wire ric_pkg::ric_cfg_s      cfg_i,
   input wire logic [7:0]             rdata_o,
   input wire logic                   irq_o,
   input wire logic                   rx_dec_en_o,
   input wire ric_pkg::ric_headroom_e headroom_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // any capture source; a collision lags its edge by one cycle
   wire cap   = ev_i.crc_err | ev_i.parity_err | ev_i.framing_err
                | ev_i.rx_edge;
   wire auto3 = cfg_i.sys_3v & cfg_i.auto_reg;

   // -------------------------------------------------------------------
   // sequences
   // -------------------------------------------------------------------
   sequence s_tx_end;
      ev_i.tx_done && !rx_dec_en_o;
   endsequence
   sequence s_irq_back;
      irq_o && rx_dec_en_o;
   endsequence
   sequence s_sof_quiet;
      ev_i.rx_sof && !irq_o && !ev_i.tx_done && !ev_i.rx_done
         && !cfg_i.vicinity;
   endsequence
   sequence s_rd2(logic [4:0] a);
      !cap ##1 (host_i.rd && host_i.addr == a && !cap) ##1 !cap
         ##1 (host_i.rd && host_i.addr == a && !cap);
   endsequence

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   AST_TX_IRQ: assert property (s_tx_end |=> s_irq_back)
      else $error("no irq after transmit end");
   AST_RX_NO_IRQ: assert property (s_sof_quiet |=> !irq_o)
      else $error("irq raised at start of frame");
   AST_DEC_OFF: assert property ($fell(rx_dec_en_o)
      |-> $past(ev_i.tx_start))
      else $error("decoder disabled without transmit start");
   AST_IRQ_PHASE_END: assert property ($rose(irq_o) && !cfg_i.vicinity
      |-> $past(ev_i.tx_done) || $past(ev_i.rx_done))
      else $error("irq raised outside a phase end");
   AST_STATUS_READ: assert property (host_i.rd
      && host_i.addr == `RIC_ADDR_IRQ_FLAGS && !ev_i.tx_done
      && !ev_i.rx_done && !cfg_i.vicinity |=> !irq_o)
      else $error("irq kept after status read");
   AST_HI_POS_CLEAR: assert property (s_rd2(5'h0D)
      |=> rdata_o[7:6] == 2'h0)
      else $error("high position bits not cleared by read");
   AST_LO_POS_CLEAR: assert property (s_rd2(5'h0E)
      |=> rdata_o == 8'h00)
      else $error("low position byte not cleared by read");
   AST_HR_250: assert property (auto3 && cfg_i.vrs[1:0] == 2'h3
      |=> headroom_o == ric_pkg::ric_hr_250mv)
      else $error("headroom code 11 wrong");
   AST_HR_350: assert property (auto3 && cfg_i.vrs[1:0] == 2'h2
      |=> headroom_o == ric_pkg::ric_hr_350mv)
      else $error("headroom code 10 wrong");
   AST_HR_400: assert property (auto3 && cfg_i.vrs[1:0] == 2'h0
      |=> headroom_o == ric_pkg::ric_hr_400mv)
      else $error("headroom code 00 wrong");
endmodule : ric_irq_monitor

// file: dv/tb.sv
/*
 * Self-checking bench of ric_irq_status with the host model.
 * Assumes shortened counts: 20-cycle bit window, 4-cycle wait tick.
 */
`timescale 1ns/1ps
`include "ric_consts.svh"

module tb;
   logic                   clk_i;
   logic                   rstn_i;
   ric_pkg::ric_host_req_s host;
   ric_pkg::ric_events_s   ev;
   ric_pkg::ric_cfg_s      cfg;
   logic [7:0]             rdata;
   logic                   irq;
   logic                   dec;
   ric_pkg::ric_headroom_e hr;
   logic [7:0]             d;
   int                     err_total = 0;
   int                     n_checks = 0;
   int                     cyc = 0;

   ric_irq_status #(.COLL_BIT_CYC(20), .NORESP_TICK(4)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .host_i(host), .ev_i(ev),
      .cfg_i(cfg), .rdata_o(rdata), .irq_o(irq), .rx_dec_en_o(dec),
      .headroom_o(hr));
   ric_host_model host_m (.clk_i(clk_i), .rdata_i(rdata), .host_o(host));

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         $display("unexpected %0t timeout", $time);
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task chk(input logic [7:0] g, input logic [7:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task rc(input logic [4:0] a, input logic [7:0] e, input string m);
      host_m.rd(a, d);
      chk(d, e, m);
   endtask : rc
   // pulse bits: tx_start tx_done sof rx_done crc parity framing edge
   task pl(input logic [7:0] m);
      @(posedge clk_i);
      ev[21:14] <= m;
      @(posedge clk_i);
      ev[21:14] <= 8'h00;
      #1;
   endtask : pl

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task t_reset;
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h00, "flags reset");
      rc(`RIC_ADDR_COLL_HI, 8'h3E, "enables reset");
      rc(`RIC_ADDR_COLL_LO, 8'h00, "position reset");
      rc(5'h1F, 8'h00, "unmapped read");
      $display("test reset done");
   endtask : t_reset
   task t_tx;
      @(posedge clk_i);
      ev.fifo_count <= 4'h2;
      pl(8'h80);
      chk({7'h00, dec}, 8'h00, "decoder in tx");
      chk({7'h00, irq}, 8'h00, "irq at tx start");
      pl(8'h08);
      pl(8'h40);
      chk({7'h00, irq}, 8'h01, "irq at tx end");
      chk({7'h00, dec}, 8'h01, "decoder after tx");
      @(posedge clk_i);
      ev.fifo_count <= 4'h6;
      rc(`RIC_ADDR_IRQ_FLAGS, 8'hA0, "tx flags");
      chk({7'h00, irq}, 8'h00, "irq after read");
      $display("test tx done");
   endtask : t_tx
   task t_rx;
      @(posedge clk_i);
      ev.fifo_count <= 4'h9;
      ev.bit_pos <= 10'h2A5;
      pl(8'h20);
      chk({7'h00, irq}, 8'h00, "irq at sof");
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h40, "rx start flag");
      pl(8'h0E);
      pl(8'h10);
      chk({7'h00, irq}, 8'h01, "irq at rx end");
      @(posedge clk_i);
      ev.fifo_count <= 4'h6;
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h3C, "rx error flags");
      rc(`RIC_ADDR_COLL_HI, 8'hBE, "error pos high");
      rc(`RIC_ADDR_COLL_HI, 8'h3E, "pos high cleared");
      rc(`RIC_ADDR_COLL_LO, 8'hA5, "error pos low");
      rc(`RIC_ADDR_COLL_LO, 8'h00, "pos low cleared");
      $display("test rx done");
   endtask : t_rx
   task t_crc_ctrl;
      @(posedge clk_i);
      cfg.no_rx_crc <= 1'b1;
      pl(8'h20);
      pl(8'h08);
      pl(8'h10);
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h40, "crc disabled");
      pl(8'h80);
      host_m.wr(`RIC_ADDR_PROTO_CTRL, 8'h00);
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h00, "control write clear");
      pl(8'h40);
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h00, "flags after tx");
      chk({7'h00, irq}, 8'h00, "irq released");
      @(posedge clk_i);
      cfg.no_rx_crc <= 1'b0;
      $display("test crc and control done");
   endtask : t_crc_ctrl
   task t_coll;
      for (int t = 0; t < 2; t++) begin
         @(posedge clk_i);
         cfg.type_a <= 1'b1;
         cfg.coll_thr7 <= t[0];
         ev.bit_pos <= 10'h155;
         pl(8'h20);
         repeat (7) pl(8'h01);
         pl(8'h10);
         rc(`RIC_ADDR_IRQ_FLAGS, t ? 8'h40 : 8'h42, "collision");
         rc(`RIC_ADDR_COLL_HI, t ? 8'h3E : 8'h7E, "coll high");
         rc(`RIC_ADDR_COLL_LO, t ? 8'h00 : 8'h55, "coll low");
      end
      $display("test collision done");
   endtask : t_coll
   task t_noresp;
      for (int en = 0; en < 2; en++) begin
         @(posedge clk_i);
         cfg.vicinity <= 1'b1;
         cfg.noresp_wait <= 8'h02;
         host_m.wr(`RIC_ADDR_COLL_HI, {7'h1F, en[0]});
         pl(8'h80);
         pl(8'h40);
         rc(`RIC_ADDR_IRQ_FLAGS, 8'h80, "tx before timeout");
         repeat (30) @(posedge clk_i);
         #1;
         chk({7'h00, irq}, {7'h00, en[0]}, "no-response irq");
         rc(`RIC_ADDR_IRQ_FLAGS, 8'h01, "no-response flag");
      end
      @(posedge clk_i);
      cfg.vicinity <= 1'b0;
      $display("test no-response done");
   endtask : t_noresp
   task t_rst;
      pl(8'h80);
      pl(8'h40);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      @(posedge clk_i);
      rstn_i <= 1'b1;
      #1;
      chk({7'h00, irq}, 8'h00, "irq after reset");
      chk(rdata, 8'h00, "read data after reset");
      rc(`RIC_ADDR_IRQ_FLAGS, 8'h00, "flags after reset");
      rc(`RIC_ADDR_COLL_HI, 8'h3E, "enables after reset");
      $display("test mid reset done");
   endtask : t_rst
   task t_head;
      logic [1:0] hx [4];
      hx = '{2'h3, 2'h0, 2'h2, 2'h1};
      @(posedge clk_i);
      cfg.sys_3v <= 1'b1;
      cfg.auto_reg <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         cfg.vrs <= i[2:0];
         repeat (2) @(posedge clk_i);
         #1;
         chk({6'h00, hr}, {6'h00, hx[i[1:0]]}, "headroom");
      end
      $display("test headroom done");
   endtask : t_head

   initial begin
      ev = '0;
      cfg = '0;
      rstn_i = 1'b0;
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_crc_ctrl();
      t_coll();
      t_noresp();
      t_rst();
      t_head();
      complete_run();
   end
endmodule : tb

bind ric_irq_status ric_irq_monitor u_mon (
   .clk_i(clk_i), .rstn_i(rstn_i), .host_i(host_i), .ev_i(ev_i),
   .cfg_i(cfg_i), .rdata_o(rdata_o), .irq_o(irq_o),
   .rx_dec_en_o(rx_dec_en_o), .headroom_o(headroom_o));

// file: rtl/ric_coll_detect.sv
/*
 * Collision detector: counts receive edges inside each 106 kbps bit window
 * and pulses when the count passes the selected threshold.
 * Assumes edges arrive as one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_coll_detect #(
   parameter int BIT_CYC = `RIC_CLK_KHZ / `RIC_COLL_RATE_KBPS
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic active_i,
   input  wire logic edge_i,
   input  wire logic thr7_i,
   output logic      coll_o
);

   logic [11:0] win_q;
   logic [3:0]  cnt_q;
   logic        fired_q;
   wire  logic  win_end = (win_q == 12'(BIT_CYC - 1));
   wire  logic [2:0] thr = thr7_i ? `RIC_COLL_THR_HI : `RIC_COLL_THR_LO;
   // saturate so a noisy window cannot wrap the count back below threshold
   wire  logic [3:0] cnt_inc = (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
   wire  logic [3:0] cnt_nx  = edge_i ? cnt_inc : cnt_q;
   wire  logic over = (cnt_nx > {1'b0, thr});

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         win_q   <= 12'h000;
         cnt_q   <= 4'h0;
         fired_q <= 1'b0;
         coll_o  <= 1'b0;
      end else if (!active_i || win_end) begin
         win_q   <= 12'h000;
         cnt_q   <= 4'h0;
         fired_q <= 1'b0;
         coll_o  <= 1'b0;
      end else begin
         win_q   <= win_q + 12'h001;
         cnt_q   <= cnt_nx;
         fired_q <= fired_q | over;
         coll_o  <= over & ~fired_q;
      end
   end

endmodule : ric_coll_detect

// file: rtl/ric_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * reader interrupt status and collision position block.
 * Assumes a 100 MHz system clock; included by its bare name.
 */
`ifndef RIC_CONSTS_SVH
`define RIC_CONSTS_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define RIC_ADDR_PROTO_CTRL  5'h01
`define RIC_ADDR_IRQ_FLAGS   5'h0C
`define RIC_ADDR_COLL_HI     5'h0D
`define RIC_ADDR_COLL_LO     5'h0E

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RIC_FLAGS_RST        8'h00
`define RIC_ENABLES_RST      6'h3E
`define RIC_COLL_POS_RST     10'h000

// ---------------------------------------------------------------------------
// interrupt flag bit positions
// ---------------------------------------------------------------------------
`define RIC_B_TX             7
`define RIC_B_RX_START       6
`define RIC_B_FIFO           5
`define RIC_B_CRC            4
`define RIC_B_PARITY         3
`define RIC_B_FRAMING        2
`define RIC_B_COLL           1
`define RIC_B_NORESP         0

// ---------------------------------------------------------------------------
// fifo thresholds, collision edge thresholds, regulator codes
// ---------------------------------------------------------------------------
`define RIC_FIFO_RX_HIGH     4'h8
`define RIC_FIFO_TX_LOW      4'h4
`define RIC_COLL_THR_LO      3'h6
`define RIC_COLL_THR_HI      3'h7
`define RIC_VRS_250MV        2'h3
`define RIC_VRS_350MV        2'h2
`define RIC_VRS_400MV        2'h0

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define RIC_CLK_KHZ          100000
`define RIC_COLL_RATE_KBPS   106
`define RIC_NORESP_TICK_CYC  1000

`endif

// file: rtl/ric_irq_status.sv
/*
 * Interrupt status, interrupt enables and collision/error position logic
 * of a 13.56 MHz reader front-end, with the automatic 3-V headroom decode.
 * Assumes the host register port, the protocol events and the protocol
 * control bits all come from logic on the same clock; events are one-cycle
 * pulses, fifo_count and cfg are levels.
 */
`timescale 1ns/1ps
`include "ric_consts.svh"

// Functional notes
// - status cleared at reset and control write
// - end of status read clears flags, IRQ
// - transmit: decoder off, only bits 7,5
// - receive: only bit 6, no IRQ yet
// - IRQ only at phase end or enabled no-response
// - bit 7 at transmit start, IRQ at end
// - bit 6 at start-of-frame, IRQ at end
// - FIFO flag: above 8 rx, below 4 tx
// - CRC error flagged unless CRC disabled
// - parity bit 3, framing bit 2
// - collision when edges exceed 6 or 7
// - vicinity only: no-response flag after wait
// - mask register resets 0x3E, position clears on read
// - position bits 9,8 in mask bits 7,6
// - enables bits 5..1 default one, bit0 zero
// - low position byte resets zero, clears on read
// - auto 3-V headroom 250, 350, 400 mV
module ric_irq_status #(
   parameter int COLL_BIT_CYC = `RIC_CLK_KHZ / `RIC_COLL_RATE_KBPS,
   parameter int NORESP_TICK  = `RIC_NORESP_TICK_CYC
) (
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire ric_pkg::ric_host_req_s host_i,
   input  wire ric_pkg::ric_events_s   ev_i,
   input  wire ric_pkg::ric_cfg_s      cfg_i,
   output logic [7:0]                  rdata_o,
   output logic                        irq_o,
   output logic                        rx_dec_en_o,
   output ric_pkg::ric_headroom_e      headroom_o
);

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   ric_pkg::ric_phase_e phase_q;
   ric_pkg::ric_phase_e phase_d;
   logic [7:0]          flags_q;
   logic [7:0]          flags_d;
   logic [5:0]          pend_q;
   logic [5:0]          pend_d;
   logic [5:0]          en_q;
   logic [9:0]          pos_q;
   logic [9:0]          pos_d;
   logic                irq_d;
   logic                coll_pulse;
   logic                noresp_pulse;

   // ------------------------------------------------------------------------
   // host port decode
   // ------------------------------------------------------------------------
   wire logic sel_ctrl  = (host_i.addr == `RIC_ADDR_PROTO_CTRL);
   wire logic sel_flags = (host_i.addr == `RIC_ADDR_IRQ_FLAGS);
   wire logic sel_hi    = (host_i.addr == `RIC_ADDR_COLL_HI);
   wire logic sel_lo    = (host_i.addr == `RIC_ADDR_COLL_LO);
   wire logic wr_ctrl   = host_i.wr & sel_ctrl;
   wire logic wr_hi     = host_i.wr & sel_hi;
   wire logic rd_flags  = host_i.rd & sel_flags;
   wire logic rd_hi     = host_i.rd & sel_hi;
   wire logic rd_lo     = host_i.rd & sel_lo;
   // a status read ends in the cycle of the read strobe
   wire logic flags_clr = rd_flags | wr_ctrl;

   wire logic [7:0] rd_mux;
   assign rd_mux = sel_flags ? flags_q :
                   sel_hi    ? {pos_q[9:8], en_q} :
                   sel_lo    ? pos_q[7:0] :
                               8'h00;

   // ------------------------------------------------------------------------
   // phase tracking
   // ------------------------------------------------------------------------
   wire logic in_tx = (phase_q == ric_pkg::ric_ph_tx);
   wire logic in_rx = (phase_q == ric_pkg::ric_ph_rx);
   wire logic in_idle = (phase_q == ric_pkg::ric_ph_idle);
   wire logic tx_end = in_tx & ev_i.tx_done;
   wire logic rx_end = in_rx & ev_i.rx_done;

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         ric_pkg::ric_ph_idle: begin
            if (ev_i.tx_start) begin
               phase_d = ric_pkg::ric_ph_tx;
            end else if (ev_i.rx_sof) begin
               phase_d = ric_pkg::ric_ph_rx;
            end
         end
         ric_pkg::ric_ph_tx: begin
            if (ev_i.tx_done) begin
               phase_d = ric_pkg::ric_ph_idle;
            end
         end
         ric_pkg::ric_ph_rx: begin
            if (ev_i.rx_done) begin
               phase_d = ric_pkg::ric_ph_idle;
            end
         end
         default: begin
            phase_d = ric_pkg::ric_ph_idle;
         end
      endcase
   end

   // ------------------------------------------------------------------------
   // event sources
   // ------------------------------------------------------------------------
   wire logic tx_start_ok = in_idle & ev_i.tx_start;
   wire logic sof_ok      = in_idle & ev_i.rx_sof;
   wire logic fifo_rx_hi  = in_rx & (ev_i.fifo_count > `RIC_FIFO_RX_HIGH);
   wire logic fifo_tx_lo  = in_tx & (ev_i.fifo_count < `RIC_FIFO_TX_LOW);
   wire logic crc_ev      = in_rx & ev_i.crc_err & ~cfg_i.no_rx_crc;
   wire logic parity_ev   = in_rx & ev_i.parity_err;
   wire logic framing_ev  = in_rx & ev_i.framing_err;
   wire logic noresp_ev   = noresp_pulse & cfg_i.vicinity;
   wire logic any_err     = crc_ev | parity_ev | framing_ev;

   ric_coll_detect #(
      .BIT_CYC (COLL_BIT_CYC)
   ) u_coll (
      .clk_i    (clk_i),
      .rstn_i   (rstn_i),
      .active_i (in_rx),
      .edge_i   (ev_i.rx_edge),
      .thr7_i   (cfg_i.coll_thr7),
      .coll_o   (coll_pulse)
   );

   // timer runs from end of transmit to start-of-frame or transmit start
   ric_noresp_timer #(
      .TICK_CYC (NORESP_TICK)
   ) u_noresp (
      .clk_i     (clk_i),
      .rstn_i    (rstn_i),
      .start_i   (tx_end),
      .stop_i    (ev_i.rx_sof | ev_i.tx_start),
      .wait_i    (cfg_i.noresp_wait),
      .expired_o (noresp_pulse)
   );

   // ------------------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------------------
   // receive-phase sources wait in pend_q so the visible register only
   // changes bit 6 until the frame is over
   wire logic [5:0] pend_set = {fifo_rx_hi, crc_ev, parity_ev, framing_ev,
                                coll_pulse & in_rx, 1'b0};

   always_comb begin
      pend_d = pend_q | pend_set;
      if (rx_end || tx_start_ok || wr_ctrl) begin
         pend_d = 6'h00;
      end
   end

   wire logic [7:0] tx_set  = {tx_start_ok, 1'b0, fifo_tx_lo,
                               5'h00};
   wire logic [7:0] rx_set  = {1'b0, sof_ok, 6'h00};
   wire logic [7:0] end_set = rx_end ? {2'b00, pend_q | pend_set} : 8'h00;
   wire logic [7:0] nr_set  = {7'h00, noresp_ev};

   always_comb begin
      flags_d = flags_clr ? `RIC_FLAGS_RST : flags_q;
      // an event in the clearing cycle survives the clear
      flags_d = flags_d | tx_set | rx_set | end_set | nr_set;
   end

   // ------------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------------
   // end of a phase always interrupts; the no-response source needs its
   // enable, and gated error/fifo causes are folded into the receive end
   wire logic [5:0] gated = (pend_q | pend_set) & en_q;
   wire logic rx_irq = rx_end & (1'b1 | (|gated));
   wire logic nr_irq = noresp_ev & en_q[`RIC_B_NORESP];
   wire logic irq_set = tx_end | rx_irq | nr_irq;

   always_comb begin
      irq_d = flags_clr ? 1'b0 : irq_o;
      irq_d = irq_d | irq_set;
   end

   // ------------------------------------------------------------------------
   // collision or error position
   // ------------------------------------------------------------------------
   wire logic pos_cap_a   = cfg_i.type_a & coll_pulse & in_rx;
   wire logic pos_cap_err = ~cfg_i.type_a & any_err;
   wire logic pos_cap     = pos_cap_a | pos_cap_err;

   always_comb begin
      pos_d = pos_q;
      if (rd_hi) begin
         pos_d[9:8] = 2'b00;
      end
      if (rd_lo) begin
         pos_d[7:0] = 8'h00;
      end
      if (pos_cap) begin
         pos_d = ev_i.bit_pos;
      end
   end

   // ------------------------------------------------------------------------
   // regulator headroom decode
   // ------------------------------------------------------------------------
   wire logic auto_3v = cfg_i.sys_3v & cfg_i.auto_reg;
   wire logic [1:0] vrs_lo = cfg_i.vrs[1:0]; // bit 2 ignored
   ric_pkg::ric_headroom_e hr_d;

   always_comb begin
      hr_d = ric_pkg::ric_hr_none;
      if (auto_3v) begin
         if (vrs_lo == `RIC_VRS_250MV) begin
            hr_d = ric_pkg::ric_hr_250mv;
         end else if (vrs_lo == `RIC_VRS_350MV) begin
            hr_d = ric_pkg::ric_hr_350mv;
         end else if (vrs_lo == `RIC_VRS_400MV) begin
            hr_d = ric_pkg::ric_hr_400mv;
         end
      end
   end

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_q <= ric_pkg::ric_ph_idle;
      end else begin
         phase_q <= phase_d;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags_q <= `RIC_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_q <= 6'h00;
      end else begin
         pend_q <= pend_d;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_d;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_q <= `RIC_ENABLES_RST;
      end else if (wr_hi) begin
         en_q <= host_i.wdata[5:0];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pos_q <= `RIC_COLL_POS_RST;
      end else begin
         pos_q <= pos_d;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (host_i.rd) begin
         rdata_o <= rd_mux;
      end
   end

   // decoder is held off for the whole transmit phase
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_dec_en_o <= 1'b1;
      end else begin
         rx_dec_en_o <= (phase_d != ric_pkg::ric_ph_tx);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         headroom_o <= ric_pkg::ric_hr_none;
      end else begin
         headroom_o <= hr_d;
      end
   end

endmodule : ric_irq_status

// file: rtl/ric_noresp_timer.sv
/*
 * No-response timer: started at the end of a transmit, stopped by a
 * start-of-frame, pulses when the programmed wait has passed.
 * Assumes the wait value is stable while the timer runs.
 */
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_noresp_timer #(
   parameter int TICK_CYC = `RIC_NORESP_TICK_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       start_i,
   input  wire logic       stop_i,
   input  wire logic [7:0] wait_i,
   output logic            expired_o
);

   logic        run_q;
   logic [19:0] div_q;
   logic [7:0]  tick_cnt_q;
   wire  logic  tick = (div_q == 20'(TICK_CYC - 1));
   wire  logic  done = run_q & tick & (tick_cnt_q >= wait_i);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         run_q      <= 1'b0;
         div_q      <= 20'h00000;
         tick_cnt_q <= 8'h00;
         expired_o  <= 1'b0;
      end else begin
         expired_o <= done & ~stop_i;
         if (start_i) begin
            run_q      <= 1'b1;
            div_q      <= 20'h00000;
            tick_cnt_q <= 8'h00;
         end else if (stop_i || done) begin
            run_q <= 1'b0;
         end else if (run_q) begin
            div_q <= tick ? 20'h00000 : div_q + 20'h00001;
            if (tick) begin
               tick_cnt_q <= tick_cnt_q + 8'h01;
            end
         end
      end
   end

endmodule : ric_noresp_timer

// file: rtl/ric_pkg.sv
/*
 * Types shared by the interrupt status and collision position block.
 * Assumes the constants header is included by each user.
 */
package ric_pkg;

   // ------------------------------------------------------------------------
   // phase and regulator encodings
   // ------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ric_ph_idle,
      ric_ph_tx,
      ric_ph_rx
   } ric_phase_e;

   typedef enum logic [1:0] {
      ric_hr_none,
      ric_hr_250mv,
      ric_hr_350mv,
      ric_hr_400mv
   } ric_headroom_e;

   // ------------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } ric_host_req_s;

   typedef struct packed {
      logic       tx_start;
      logic       tx_done;
      logic       rx_sof;
      logic       rx_done;
      logic       crc_err;
      logic       parity_err;
      logic       framing_err;
      logic       rx_edge;
      logic [3:0] fifo_count;
      logic [9:0] bit_pos;
   } ric_events_s;

   typedef struct packed {
      logic       no_rx_crc;
      logic       coll_thr7;
      logic       vicinity;
      logic       type_a;
      logic       sys_3v;
      logic       auto_reg;
      logic [2:0] vrs;
      logic [7:0] noresp_wait;
   } ric_cfg_s;

endpackage : ric_pkg
